/* File: include/adc_ctrl_map.vh */
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH

// register addresses on the serial port
`define ADDR_CONV_CFG   4'h5
`define ADDR_EVENT_CFG  4'h6
`define ADDR_STATE_RPT  4'h7
`define ADDR_TRIG_MODE  4'h8
`define ADDR_SOFT_RST   4'h9

// reset values
`define CONV_CFG_RST    8'h00
`define EVENT_CFG_RST   8'h00
`define TRIG_MODE_RST   8'h02
`define SOFT_RST_KEY    8'hAA

// converter_config_reg fields
`define CFG_SPI_START   0
`define CFG_BUF_EN      1
`define CFG_BUSY_MODE   2
`define CFG_ACT_HIGH    3
`define CFG_EDGE_EVT    4

// event_config_reg fields
`define EVT_DATA_RDY    0
`define EVT_SCAN_DONE   1
`define EVT_BUF_FULL    2
`define EVT_NOT_EMPTY   3
`define EVT_POWER_DOWN  7

// state_report_reg fields
`define RPT_POWER_DOWN  0

// trigger modes at or above this value run auto-trigger
`define TRIG_AUTO_MIN   3'h4

// serial commands, upper nibble of the frame
`define CMD_REG_READ    4'h4
`define CMD_REG_WRITE   4'h8
`define CMD_ADC_READ    4'hD

// timing in half conversion-clock periods
`define ACQ_HALVES      17
`define CONV_HALVES     27
`define AUTO_GAP_CONVERSION_CLOCK   18
`define AUTO_GAP_HALVES (`AUTO_GAP_CONVERSION_CLOCK * 2)

// clock rates and wake-up time
`define CLK_MHZ         25
`define CONVERSION_CLOCK_MHZ        4
`define WAKE_US         40
`define WAKE_CYCLES     (`WAKE_US * `CLK_MHZ)

// serial result frame width
`define FRAME_BITS      20

`endif

/* File: logic/conv_clock_gen.v */
`timescale 1ns/10ps
// half-period ticks of the conversion clock, made from the system clock
// by a phase accumulator so the average rate is exact
module conv_clock_gen #(
  parameter CLK_MHZ  = 25,               // system clock rate
  parameter CONVERSION_CLOCK_MHZ = 4                 // conversion clock rate
) (
  input  wire clock,                     // system clock
  input  wire rst_n,                     // synchronised reset, active low
  input  wire run,                       // oscillator running
  output reg  half_tick                  // one pulse per half period
);

  localparam [7:0] STEP = 2 * CONVERSION_CLOCK_MHZ;
  localparam [7:0] MODV = CLK_MHZ;

  reg [7:0] acc_r;

  // accumulate, wrap and tick; stopped oscillator holds phase at zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_r     <= 8'h00;
      half_tick <= 1'b0;
    end else if (!run) begin
      acc_r     <= 8'h00;
      half_tick <= 1'b0;
    end else if (acc_r + STEP >= MODV) begin
      acc_r     <= acc_r + STEP - MODV;
      half_tick <= 1'b1;
    end else begin
      acc_r     <= acc_r + STEP;
      half_tick <= 1'b0;
    end
  end

endmodule // conv_clock_gen

/* File: logic/adc_readout_ctrl.v */
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_readout_ctrl #(
  parameter WAKE_CYCLES = `WAKE_CYCLES   // wake-up wait in system clocks
) (
  input  wire        clock,              // 25 MHz system clock
  input  wire        resetn,             // hardware reset, active low
  input  wire        sample_trigger_n,   // conversion trigger pin
  input  wire        cs_n,               // serial chip select, active low
  input  wire        sclk,               // serial clock pin
  input  wire        sdi,                // serial data in
  output reg         sdo,                // serial data out
  output reg         sdo_oe,             // sdo output enable
  output reg         status_line,        // busy or event pin
  output reg         sample_hold,        // high while acquiring
  output reg         analog_power_on,    // analog blocks powered
  input  wire [11:0] sample_value,       // converted code from the array
  input  wire [3:0]  avg_bits,           // averaging extension bits
  input  wire [3:0]  channel_tag,        // channel tag bits
  input  wire        buffer_full,        // result buffer full
  input  wire        buffer_not_empty,   // result buffer holds data
  input  wire        scan_complete       // scan of channels finished
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ACQ  = 5'h02;
  localparam [4:0] ST_CONV = 5'h04;
  localparam [4:0] ST_GAP  = 5'h08;
  localparam [4:0] ST_HALT = 5'h10;
  localparam [5:0] ACQ_LAST  = `ACQ_HALVES - 1;
  localparam [5:0] CONV_LAST = `CONV_HALVES - 1;
  localparam [5:0] GAP_LAST  = `AUTO_GAP_HALVES - 1;
  localparam [10:0] WAKE_LOAD = WAKE_CYCLES;

  reg  [1:0]  rst_sync_r;
  wire        rst_n;
  reg  [3:0]  pin_s1_r;
  reg  [3:0]  pin_s2_r;
  reg  [3:0]  pin_s3_r;
  reg  [3:0]  pin_r;
  reg  [3:0]  pin_d_r;
  wire        trig_fall;
  wire        cs_fall;
  wire        cs_rise;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        selected;
  reg  [7:0]  conv_cfg_r;
  reg  [7:0]  event_cfg_r;
  reg  [2:0]  trig_mode_r;
  reg  [4:0]  state_r;
  reg  [4:0]  state_nxt;
  reg  [5:0]  half_cnt_r;
  reg  [5:0]  half_cnt_nxt;
  reg         conv_done;
  wire        half_tick;
  wire        auto_mode;
  wire        powered;
  reg         pd_d_r;
  reg  [10:0] wake_cnt_r;
  reg  [19:0] holding_r;
  reg  [19:0] out_sr_r;
  reg  [15:0] rx_sr_r;
  reg  [4:0]  bit_cnt_r;
  reg         ones_pend_r;
  reg         ones_frame_r;
  reg         spi_start_r;
  reg         wr_pulse_r;
  reg  [3:0]  wr_addr_r;
  reg  [7:0]  wr_data_r;
  wire        soft_rst;
  wire        start_req;
  reg         full_d_r;
  reg         rdy_pend_r;
  wire        rdy_en;
  wire        full_en;
  wire        level_causes;
  wire        event_on;
  wire        busy;

  // register read decode
  function [7:0] reg_read;
    input [3:0] addr;
    input [7:0] cfg;
    input [7:0] evt;
    input [2:0] mode;
    input       pwr;
    begin
      case (addr)
        `ADDR_CONV_CFG:  reg_read = cfg;
        `ADDR_EVENT_CFG: reg_read = evt;
        `ADDR_STATE_RPT: reg_read = {7'h00, ~pwr};
        `ADDR_TRIG_MODE: reg_read = {5'h00, mode};
        default:         reg_read = 8'h00;
      endcase
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pin synchronisers: trigger, chip select, sclk, sdi
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_r[gi] <= 1'b1;
          pin_s2_r[gi] <= 1'b1;
          pin_s3_r[gi] <= 1'b1;
          pin_r[gi]    <= 1'b1;
          pin_d_r[gi]  <= 1'b1;
        end else begin
          pin_s1_r[gi] <= (gi == 0) ? sample_trigger_n :
                          (gi == 1) ? cs_n :
                          (gi == 2) ? sclk : sdi;
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_r[gi] <= pin_s3_r[gi];
          end
          pin_d_r[gi] <= pin_r[gi];
        end
      end
    end
  endgenerate

  // edges of the stable pin copies
  assign trig_fall = pin_d_r[0] & ~pin_r[0];
  assign cs_fall   = pin_d_r[1] & ~pin_r[1];
  assign cs_rise   = ~pin_d_r[1] & pin_r[1];
  assign sclk_rise = ~pin_d_r[2] & pin_r[2];
  assign sclk_fall = pin_d_r[2] & ~pin_r[2];
  assign selected  = ~pin_r[1];

  assign soft_rst  = wr_pulse_r & (wr_addr_r == `ADDR_SOFT_RST) &
                     (wr_data_r == `SOFT_RST_KEY) & powered;
  assign auto_mode = (trig_mode_r >= `TRIG_AUTO_MIN);

  // conversion clock, stopped while powered down
  conv_clock_gen #(
    .CLK_MHZ  (`CLK_MHZ),
    .CONVERSION_CLOCK_MHZ (`CONVERSION_CLOCK_MHZ)
  ) u_conversion_clock (
    .clock     (clock),
    .rst_n     (rst_n),
    .run       (~event_cfg_r[`EVT_POWER_DOWN]),
    .half_tick (half_tick)
  );

  // power-down entry, wake-up wait and status
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_d_r     <= 1'b0;
      wake_cnt_r <= 11'h000;
    end else begin
      pd_d_r <= event_cfg_r[`EVT_POWER_DOWN];
      if (pd_d_r & ~event_cfg_r[`EVT_POWER_DOWN]) begin
        wake_cnt_r <= WAKE_LOAD;
      end else if (wake_cnt_r != 11'h000) begin
        wake_cnt_r <= wake_cnt_r - 11'h001;
      end
    end
  end
  assign powered = ~event_cfg_r[`EVT_POWER_DOWN] &
                   (wake_cnt_r == 11'h000);

  // start source: pin regardless of select, or serial command
  assign start_req = powered &
                     (conv_cfg_r[`CFG_SPI_START] ? spi_start_r
                                                 : trig_fall);

  // conversion sequencer
  always @* begin
    state_nxt    = state_r;
    half_cnt_nxt = half_cnt_r;
    conv_done    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start_req) begin
          state_nxt    = ST_ACQ;
          half_cnt_nxt = 6'h00;
        end
      end
      ST_ACQ: begin
        if (half_tick) begin
          half_cnt_nxt = half_cnt_r + 6'h01;
          if (half_cnt_r == ACQ_LAST) begin
            state_nxt    = ST_CONV;
            half_cnt_nxt = 6'h00;
          end
        end
      end
      ST_CONV: begin
        if (half_tick) begin
          half_cnt_nxt = half_cnt_r + 6'h01;
          if (half_cnt_r == CONV_LAST) begin
            conv_done    = 1'b1;
            half_cnt_nxt = 6'h00;
            state_nxt    = auto_mode ? ST_GAP : ST_IDLE;
          end
        end
      end
      ST_GAP: begin
        if (!auto_mode) begin
          state_nxt = ST_IDLE;
        end else if (half_tick) begin
          half_cnt_nxt = half_cnt_r + 6'h01;
          if (half_cnt_r == GAP_LAST) begin
            state_nxt    = ST_CONV;
            half_cnt_nxt = 6'h00;
          end
        end
      end
      ST_HALT: begin
        if (powered) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt    = ST_IDLE;
        half_cnt_nxt = 6'h00;
      end
    endcase
    if (!powered) begin
      state_nxt    = ST_HALT;
      half_cnt_nxt = 6'h00;
      conv_done    = 1'b0;
    end
  end

  // sequencer state and result holding register
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      half_cnt_r <= 6'h00;
      holding_r  <= 20'h00000;
    end else if (soft_rst) begin
      state_r    <= ST_IDLE;
      half_cnt_r <= 6'h00;
      holding_r  <= 20'h00000;
    end else begin
      state_r    <= state_nxt;
      half_cnt_r <= half_cnt_nxt;
      if (conv_done) begin
        holding_r <= {sample_value, avg_bits, channel_tag};
      end
    end
  end

  // serial receive: command, address, data on rising sclk
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_r     <= 16'h0000;
      bit_cnt_r   <= 5'h00;
      spi_start_r <= 1'b0;
      wr_pulse_r  <= 1'b0;
      wr_addr_r   <= 4'h0;
      wr_data_r   <= 8'h00;
    end else begin
      spi_start_r <= 1'b0;
      wr_pulse_r  <= 1'b0;
      if (cs_fall) begin
        bit_cnt_r <= 5'h00;
      end else if (selected & sclk_rise) begin
        rx_sr_r <= {rx_sr_r[14:0], pin_r[3]};
        if (bit_cnt_r != 5'h1F) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        if (bit_cnt_r == 5'h03 &&
            {rx_sr_r[2:0], pin_r[3]} == `CMD_ADC_READ) begin
          spi_start_r <= 1'b1;
        end
        if (bit_cnt_r == 5'h0F && rx_sr_r[14:11] == `CMD_REG_WRITE) begin
          wr_pulse_r <= 1'b1;
          wr_addr_r  <= rx_sr_r[10:7];
          wr_data_r  <= {rx_sr_r[6:0], pin_r[3]};
        end
      end
    end
  end

  // configuration registers; 05h only while the converter idles, 06h while it idles or is halted
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_cfg_r  <= `CONV_CFG_RST;
      event_cfg_r <= `EVENT_CFG_RST;
      trig_mode_r <= 3'h2;
    end else if (soft_rst) begin
      conv_cfg_r  <= `CONV_CFG_RST;
      event_cfg_r <= `EVENT_CFG_RST;
      trig_mode_r <= 3'h2;
    end else if (wr_pulse_r) begin
      case (wr_addr_r)
        `ADDR_CONV_CFG: begin
          if (state_r == ST_IDLE) begin
            conv_cfg_r <= wr_data_r;
          end
        end
        `ADDR_EVENT_CFG: begin
          if (state_r == ST_IDLE || state_r == ST_HALT) begin
            event_cfg_r <= wr_data_r;
          end
        end
        `ADDR_TRIG_MODE: begin
          trig_mode_r <= wr_data_r[2:0];
        end
        default: begin
          trig_mode_r <= trig_mode_r;
        end
      endcase
    end
  end

  // serial transmit: load on chip-select fall, shift on falling sclk
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_sr_r     <= 20'hFFFFF;
      ones_pend_r  <= 1'b1;
      ones_frame_r <= 1'b1;
      sdo          <= 1'b1;
      sdo_oe       <= 1'b0;
    end else begin
      // pending flag is used up by the next frame; a soft reset
      // written inside a frame survives its chip-select rise
      if (cs_fall) begin
        ones_pend_r  <= 1'b0;
        ones_frame_r <= ones_pend_r;
      end
      if (soft_rst) begin
        ones_pend_r <= 1'b1;
      end
      if (cs_fall) begin
        out_sr_r <= ones_pend_r ? 20'hFFFFF : holding_r;
      end else if (selected & sclk_rise & (bit_cnt_r == 5'h07) &
                   (rx_sr_r[6:3] == `CMD_REG_READ)) begin
        out_sr_r <= {1'b0,
                     reg_read({rx_sr_r[2:0], pin_r[3]}, conv_cfg_r,
                              event_cfg_r, trig_mode_r, powered),
                     11'h000};
      end else if (selected & sclk_fall) begin
        out_sr_r <= {out_sr_r[18:0], ones_frame_r};
      end
      sdo    <= out_sr_r[`FRAME_BITS-1];
      sdo_oe <= selected;
    end
  end

  // event causes; set on conversion end wins over the read that clears
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      full_d_r   <= 1'b0;
      rdy_pend_r <= 1'b0;
    end else begin
      full_d_r <= buffer_full;
      if (conv_done) begin
        rdy_pend_r <= 1'b1;
      end else if (cs_fall | soft_rst) begin
        rdy_pend_r <= 1'b0;
      end
    end
  end

  assign rdy_en  = ~conv_cfg_r[`CFG_BUF_EN] &
                   event_cfg_r[`EVT_DATA_RDY];
  assign full_en = conv_cfg_r[`CFG_BUF_EN] &
                   event_cfg_r[`EVT_BUF_FULL];
  assign level_causes =
    (event_cfg_r[`EVT_NOT_EMPTY] & buffer_not_empty) |
    (event_cfg_r[`EVT_SCAN_DONE] & scan_complete);
  assign event_on = level_causes |
    (conv_cfg_r[`CFG_EDGE_EVT] ?
       ((rdy_en & conv_done) | (full_en & buffer_full & ~full_d_r)) :
       ((rdy_en & rdy_pend_r) | (full_en & buffer_full)));
  assign busy = (state_r == ST_CONV);

  // status line, sample-hold and power flag outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_line     <= 1'b1;
      sample_hold     <= 1'b0;
      analog_power_on <= 1'b0;
    end else begin
      if (conv_cfg_r[`CFG_BUSY_MODE]) begin
        status_line <= conv_cfg_r[`CFG_ACT_HIGH] ? busy : ~busy;
      end else begin
        status_line <= conv_cfg_r[`CFG_ACT_HIGH] ? event_on
                                                 : ~event_on;
      end
      sample_hold     <= (state_r == ST_ACQ) | (state_r == ST_GAP);
      analog_power_on <= powered;
    end
  end

endmodule // adc_readout_ctrl

/* File: testbench/adc_ctrl_asserts.sv */
`timescale 1ns/10ps
module adc_ctrl_chk #(
  parameter WAKE_CYCLES = 1000           // wake-up wait in clocks
) (
  input wire clock,                      // system clock
  input wire resetn,                     // hardware reset, active low
  input wire cs_n,                       // chip select, active low
  input wire sclk,                       // serial clock pin
  input wire sdo,                        // serial data out
  input wire sdo_oe,                     // sdo drive enable
  input wire sample_hold,                // acquisition or auto gap
  input wire analog_power_on             // analog blocks powered
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  reg [7:0]  hi_r;                       // cycles with sample_hold high
  reg [7:0]  lo_r;                       // cycles with sample_hold low
  reg [15:0] off_r;                      // cycles powered off
  reg [4:0]  fall_r;                     // sclk falls in this frame
  reg        sclk_r;                     // sclk one clock ago
  reg        first_r;                    // first frame since reset
  // run lengths and serial bit position, all saturating
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_r    <= 8'h00;
      lo_r    <= 8'hFF;
      off_r   <= 16'(WAKE_CYCLES);
      fall_r  <= 5'h00;
      sclk_r  <= 1'b0;
      first_r <= 1'b1;
    end else begin
      hi_r   <= !sample_hold ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
      lo_r   <= sample_hold ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
      off_r  <= analog_power_on ? 16'h0000 :
                off_r + {15'h0000, off_r != 16'hFFFF};
      fall_r <= cs_n ? 5'h00 :
                fall_r + {4'h0, sclk_r & !sclk & fall_r != 5'h1F};
      sclk_r <= sclk;
      if ($fell(sdo_oe))
        first_r <= 1'b0;
    end
  end
  sequence s_desel;
    cs_n [*8];
  endsequence
  sequence s_sel;
    !cs_n [*8];
  endsequence
  a_oe_off_desel:
    assert property (s_desel |-> !sdo_oe) else $error("sdo driven idle");
  a_oe_on_sel:
    assert property (s_sel |-> sdo_oe) else $error("sdo not driven");
  a_first_ones:
    assert property (first_r && sdo_oe |-> sdo)
    else $error("first frame not all ones");
  a_tail_zero:
    assert property (sclk_r && !sclk && !cs_n && !first_r
      && fall_r >= 5'd20 |-> !sdo) else $error("tail bit not low");
  a_acq_length:
    assert property ($fell(sample_hold) |->
      hi_r inside {[8'd50:8'd57], [8'd108:8'd118]})
    else $error("acquisition length wrong");
  a_conv_length:
    assert property ($rose(sample_hold) |-> lo_r >= 8'd82)
    else $error("conversion too short");
  a_down_no_acq:
    assert property (!analog_power_on |-> !sample_hold)
    else $error("sampling while powered down");
  a_wake_time:
    assert property ($rose(analog_power_on) |-> off_r >= 16'(WAKE_CYCLES))
    else $error("wake-up too short");
endmodule // adc_ctrl_chk

bind adc_readout_ctrl adc_ctrl_chk #(.WAKE_CYCLES(WAKE_CYCLES)) adc_ctrl_chk_i (
  .clock(clock), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdo(sdo),
  .sdo_oe(sdo_oe), .sample_hold(sample_hold),
  .analog_power_on(analog_power_on));

/* File: testbench/host_model.sv */
`timescale 1ns/10ps
module host_model (
  input  wire clock,                     // system clock
  input  wire sdo,                       // serial data from device
  output reg  sample_trigger_n,          // shared trigger pin
  output reg  cs_n,                      // chip select, active low
  output reg  sclk,                      // serial clock, 320 ns
  output reg  sdi                        // serial data to device
);
  time last_trig;
  // idle pins at time zero
  initial begin
    sample_trigger_n = 1'b1;
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    last_trig = 0;
  end
  // one frame of n bits, msb first; sdo taken just before each fall
  task xfer(input [23:0] tx, input integer n, output [23:0] rx);
    integer i;
    begin
      rx = 24'h000000;
      @(negedge clock);
      cs_n = 1'b0;
      repeat (8) @(negedge clock);
      for (i = 0; i < n; i = i + 1) begin
        sdi = tx[23-i];
        sclk = 1'b1;
        repeat (4) @(negedge clock);
        rx[23-i] = sdo;
        sclk = 1'b0;
        repeat (4) @(negedge clock);
      end
      cs_n = 1'b1;
      sdi = ~sdi;
      repeat (12) @(negedge clock);
    end
  endtask
  // falling trigger pulse, spaced from the previous one
  task trigger;
    begin
      @(negedge clock);
      while ($time - last_trig < 10000) @(negedge clock);
      sample_trigger_n = 1'b0;
      last_trig = $time;
      repeat (4) @(negedge clock);
      sample_trigger_n = 1'b1;
    end
  endtask
endmodule // host_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  localparam WAKE = 200;                 // shortened wake-up count
  reg         clock, resetn;
  reg         buffer_full, buffer_not_empty, scan_complete;
  reg  [11:0] sample_value;
  reg  [3:0]  avg_bits, channel_tag;
  reg  [23:0] rx;
  reg  [19:0] rows [0:4];
  wire        trig_n, cs_n, sclk, sdi, sdo, sdo_oe;
  wire        status_line, sample_hold, analog_power_on;
  integer     n_errors, samples_checked, i, w, g;

  adc_readout_ctrl #(.WAKE_CYCLES(WAKE)) adc_readout_ctrl_i (
    .clock(clock), .resetn(resetn), .sample_trigger_n(trig_n),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .status_line(status_line), .sample_hold(sample_hold),
    .analog_power_on(analog_power_on), .sample_value(sample_value),
    .avg_bits(avg_bits), .channel_tag(channel_tag),
    .buffer_full(buffer_full), .buffer_not_empty(buffer_not_empty),
    .scan_complete(scan_complete));
  host_model host_model_i (
    .clock(clock), .sdo(sdo), .sample_trigger_n(trig_n),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

  // 25 MHz clock
  always #20 clock = ~clock;

  task chk(input [23:0] got, input [23:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    host_model_i.xfer({4'h8, a, d, 8'h00}, 16, rx);
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      host_model_i.xfer({4'h4, a, 16'h0000}, 16, rx);
      chk(rx[15:8], exp);
    end
  endtask
  // cycles until status_line shows v, bounded by lim
  task wait_lvl(input v, input integer lim, output integer n);
    begin
      n = 0;
      while (status_line !== v && n < lim) begin
        @(negedge clock);
        n = n + 1;
      end
    end
  endtask
  task end_sim;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // watchdog against a hung handshake
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    end_sim;
  end
  // main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {buffer_full, buffer_not_empty, scan_complete} = 3'b000;
    sample_value = 12'hA5C;
    avg_bits = 4'h3;
    channel_tag = 4'h9;
    n_errors = 0;
    samples_checked = 0;
    rows = '{20'h00084, 20'h00081, 20'h00022, 20'h0000F, 20'h08085};
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    repeat (10) @(negedge clock);
    host_model_i.xfer(24'h000000, 24, rx);
    chk(rx, 24'hFFFFFF);
    chk(sdo_oe, 1'b0);
    rd(4'h7, 8'h00);
    // busy mode with every event source active
    wr(4'h6, 8'h0F);
    {buffer_full, buffer_not_empty, scan_complete} = 3'b111;
    wr(4'h5, 8'h04);
    repeat (20) @(negedge clock);
    chk(status_line, 1'b1);
    host_model_i.trigger;
    wait_lvl(1'b0, 300, w);
    chk(w >= 46 && w <= 62, 1'b1);
    wait_lvl(1'b1, 200, w);
    chk(w >= 81 && w <= 88, 1'b1);
    repeat (120) @(negedge clock);
    host_model_i.xfer(24'h000000, 24, rx);
    chk(rx, 24'hA5C390);
    // trigger while selected, frame opened before conversion end
    sample_value = 12'h3C1;
    fork
      host_model_i.xfer(24'h000000, 6, rx);
      begin
        repeat (10) @(negedge clock);
        host_model_i.trigger;
      end
    join
    chk(rx[23:18], 6'h29);
    wait_lvl(1'b0, 100, w);
    wait_lvl(1'b1, 200, w);
    repeat (120) @(negedge clock);
    host_model_i.xfer(24'h000000, 24, rx);
    chk(rx, 24'h3C1390);
    // conversion started by the serial command
    wr(4'h5, 8'h05);
    sample_value = 12'h0F0;
    host_model_i.xfer({4'hD, 20'h00000}, 16, rx);
    chk(rx[23:12], 12'h3C1);
    wait_lvl(1'b1, 200, w);
    repeat (120) @(negedge clock);
    host_model_i.xfer(24'h000000, 24, rx);
    chk(rx[23:12], 12'h0F0);
    // static event levels: config, enables, inputs, expected pin
    for (i = 0; i < 5; i = i + 1) begin
      wr(4'h5, rows[i][19:12]);
      wr(4'h6, rows[i][11:4]);
      {buffer_full, buffer_not_empty, scan_complete} = rows[i][3:1];
      repeat (20) @(negedge clock);
      chk(status_line, rows[i][0]);
    end
    // data-ready event as a held level, then as a one-clock edge
    {buffer_full, buffer_not_empty, scan_complete} = 3'b000;
    wr(4'h6, 8'h01);
    wr(4'h5, 8'h00);
    host_model_i.trigger;
    wait_lvl(1'b0, 400, w);
    wait_lvl(1'b1, 120, w);
    chk(w, 120);
    host_model_i.xfer(24'h000000, 6, rx);
    chk(status_line, 1'b1);
    wr(4'h5, 8'h10);
    host_model_i.trigger;
    wait_lvl(1'b0, 400, w);
    wait_lvl(1'b1, 120, w);
    chk(w, 1);
    // buffer-full edge event
    wr(4'h5, 8'h12);
    wr(4'h6, 8'h04);
    buffer_full = 1'b1;
    wait_lvl(1'b0, 20, w);
    wait_lvl(1'b1, 20, w);
    chk(w, 1);
    // auto trigger: gap then busy, stopped inside a conversion
    buffer_full = 1'b0;
    wr(4'h5, 8'h04);
    wr(4'h8, 8'h04);
    host_model_i.trigger;
    wait_lvl(1'b0, 400, w);
    wait_lvl(1'b1, 200, w);
    wait_lvl(1'b0, 200, g);
    chk(g >= 109 && g <= 117, 1'b1);
    wait_lvl(1'b1, 200, w);
    chk(w >= 81 && w <= 88, 1'b1);
    repeat (10) @(negedge clock);
    wr(4'h8, 8'h02);
    repeat (300) @(negedge clock);
    // power-down entry, status, kept config, wake-up time
    wr(4'h6, 8'h80);
    rd(4'h7, 8'h01);
    rd(4'h5, 8'h04);
    chk(analog_power_on, 1'b0);
    host_model_i.trigger;
    repeat (100) @(negedge clock);
    chk(sample_hold, 1'b0);
    wr(4'h6, 8'h00);
    w = 0;
    while (analog_power_on !== 1'b1 && w < 400) begin
      @(negedge clock);
      w = w + 1;
    end
    chk(w >= WAKE - 25 && w <= WAKE - 5, 1'b1);
    rd(4'h7, 8'h00);
    // soft reset re-arms the all-ones frame
    wr(4'h9, 8'hAA);
    host_model_i.xfer(24'h000000, 16, rx);
    chk(rx[23:8], 16'hFFFF);
    end_sim;
  end
endmodule // testbench
